// ===== hw/cifc_pkg.sv
// Package for the codec interrupt and fault power-down control block.
// Assumes a single 100 MHz clock and an 8-bit register port.
package cifc_pkg;

    localparam int unsigned CLK_MHZ          = 100;
    localparam int unsigned PULSE_MS         = 2;
    localparam int unsigned PERIOD_MS        = 4;
    // Cycles per millisecond is CLK_MHZ * 1000; the period must fit TMR_W
    localparam int unsigned PULSE_CYC_DFLT   = PULSE_MS * CLK_MHZ * 1000;
    localparam int unsigned PERIOD_CYC_DFLT  = PERIOD_MS * CLK_MHZ * 1000;
    localparam int unsigned TMR_W            = 24;

    localparam int unsigned NSRC             = 8;

    localparam logic [7:0] ADDR_IRQ_CFG      = 8'h42;
    localparam logic [7:0] ADDR_DAC_CFG      = 8'h43;
    localparam logic [7:0] ADDR_STICKY       = 8'h44;
    localparam logic [7:0] ADDR_LIVE         = 8'h45;
    localparam logic [7:0] ADDR_MASK         = 8'h46;
    localparam logic [7:0] ADDR_CTRL         = 8'h47;
    localparam logic [7:0] ADDR_EV_STS       = 8'h48;
    localparam logic [7:0] ADDR_EV_CLR       = 8'h49;
    localparam logic [7:0] ADDR_EV_EN        = 8'h4a;

    localparam logic [7:0] IRQ_CFG_RST       = 8'h00;
    localparam logic [7:0] DAC_CFG_RST       = 8'h50;
    localparam logic [7:0] MASK_RST          = 8'hff;

    // Fault source positions within the source vector
    localparam int unsigned SRC_DRV_VG       = 0;
    localparam int unsigned SRC_DRV_SC       = 1;
    localparam int unsigned SRC_REG_SC       = 2;
    localparam int unsigned SRC_ADC_FIRST    = 3;

    localparam logic [1:0] PD_IGNORE         = 2'h0;
    localparam logic [1:0] PD_UNMASKED       = 2'h1;
    localparam logic [1:0] PD_ALL            = 2'h2;

    typedef enum logic [1:0] {
        CIFC_MODE_STICKY = 2'h0,
        CIFC_MODE_LIVE   = 2'h1,
        CIFC_MODE_REPEAT = 2'h2,
        CIFC_MODE_ONCE   = 2'h3
    } cifc_mode_type;

    typedef struct packed {
        logic          irq_polarity_sel;
        cifc_mode_type mode;
        logic [1:0]    adc_fault_powerdown_sel;
        logic          sticky_readback_sel;
        logic          adc_fault_recovery_sel;
        logic          sticky_clear_policy;
    } cifc_irq_cfg_type;

    typedef struct packed {
        logic       rsvd;
        logic [1:0] dac_fault_powerdown_sel;
        logic       dac_fault_recovery_sel;
        logic       output_fault_pd_flag;
        logic       dac_startup_fault_pd_inhibit;
        logic       dac_fault_detect_off;
        logic       regulator_short_detect_off;
    } cifc_dac_cfg_type;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } cifc_bus_type;

endpackage

// ===== hw/cifc_sync.sv
// Two-flop synchroniser bank for asynchronous fault pins.
// Assumes the inputs are levels that stay stable for several clocks.
`timescale 1ns/10ps
module cifc_sync #(
    parameter int unsigned W = 8
) (
    input  wire logic         mclk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_r;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            meta_r <= '0;
            q      <= '0;
        end else begin
            meta_r <= d;
            q      <= meta_r;
        end
    end
endmodule // cifc_sync

// ===== hw/cifc_top.sv
// Interrupt pin and fault power-down control for a mono codec.
// Assumes one 100 MHz clock, fault pins asynchronous, simple register port.
//
// The strobed register port was chosen for this implementation.
`timescale 1ns/10ps
module cifc_top
    import cifc_pkg::*;
#(
    parameter int unsigned PULSE_CYC  = PULSE_CYC_DFLT,
    parameter int unsigned PERIOD_CYC = PERIOD_CYC_DFLT
) (
    input  wire logic                mclk,
    input  wire logic                rst_n,
    input  wire cifc_pkg::cifc_bus_type bus,
    output logic [7:0]               rdata,
    input  wire logic [cifc_pkg::NSRC-1:0] fault_pin,
    input  wire logic                dac_powering_up,
    input  wire logic                adc_repower,
    input  wire logic                dac_repower,
    output logic                     irq_pin,
    output logic                     adc_pd,
    output logic                     dac_pd,
    output logic                     ev_irq
);
    import cifc_pkg::*;

    logic [NSRC-1:0]   fault_s;
    logic [NSRC-1:0]   live;
    logic [NSRC-1:0]   live_d_r;
    logic [NSRC-1:0]   rise;
    logic [NSRC-1:0]   sticky_r, sticky_nxt;
    logic [NSRC-1:0]   mask_r, mask_nxt;
    cifc_irq_cfg_type  icfg_r, icfg_nxt;
    cifc_dac_cfg_type  dcfg_r, dcfg_nxt;
    logic              adc_pd_r, adc_pd_nxt;
    logic              dac_pd_r, dac_pd_nxt;
    logic [TMR_W-1:0]  tmr_r, tmr_nxt;
    logic              pulse_on_r, pulse_on_nxt;
    logic              irq_r, irq_nxt;
    logic [7:0]        rdata_r, rdata_nxt;
    logic [1:0]        ev_sts_r, ev_sts_nxt;
    logic [1:0]        ev_en_r, ev_en_nxt;
    logic              ev_irq_r, ev_irq_nxt;
    logic [NSRC-1:0]   unm_sticky;
    logic [NSRC-1:0]   unm_live;
    logic              adc_flt, dac_flt;
    logic              assert_lvl;

    cifc_sync #(.W(NSRC)) u_sync (
        .mclk (mclk),
        .rst_n(rst_n),
        .d    (fault_pin),
        .q    (fault_s)
    );

    // Detection disables gate the live sources themselves
    always_comb begin
        live = fault_s;
        if (dcfg_r.dac_fault_detect_off) begin
            live[SRC_DRV_VG] = 1'b0;
            live[SRC_DRV_SC] = 1'b0;
        end
        if (dcfg_r.regulator_short_detect_off)
            live[SRC_REG_SC] = 1'b0;
        rise       = live & ~live_d_r;
        unm_sticky = sticky_r & ~mask_r;
        unm_live   = live & ~mask_r;
    end

    // Configuration, mask and sticky flags
    always_comb begin
        logic [NSRC-1:0] clr;
        clr        = '0;
        icfg_nxt   = icfg_r;
        dcfg_nxt   = dcfg_r;
        mask_nxt   = mask_r;
        ev_en_nxt  = ev_en_r;
        if (bus.wr) begin
            unique case (bus.addr)
                ADDR_IRQ_CFG: icfg_nxt = cifc_irq_cfg_type'(bus.wdata);
                ADDR_DAC_CFG: begin
                    dcfg_nxt = cifc_dac_cfg_type'(bus.wdata);
                    dcfg_nxt.rsvd = 1'b0;
                    dcfg_nxt.output_fault_pd_flag = dcfg_r.output_fault_pd_flag;
                end
                ADDR_MASK:    mask_nxt  = bus.wdata;
                ADDR_EV_EN:   ev_en_nxt = bus.wdata[1:0];
                default:      ;
            endcase
        end
        if (bus.rd && bus.addr == ADDR_STICKY) begin
            // Policy 0 keeps bits whose source is still active
            clr = icfg_r.sticky_clear_policy ? '1 : ~live;
            if (icfg_r.sticky_readback_sel)
                clr = clr & ~mask_r;
        end
        sticky_nxt = (sticky_r & ~clr) | live;
        dcfg_nxt.output_fault_pd_flag = dac_pd_r;
    end

    // Fault power-down control for ADC/micbias and DAC
    always_comb begin
        logic [NSRC-1:0] dac_src;
        adc_flt = 1'b0;
        dac_flt = 1'b0;
        unique case (icfg_r.adc_fault_powerdown_sel)
            PD_UNMASKED: adc_flt = |unm_live[NSRC-1:SRC_ADC_FIRST];
            PD_ALL:      adc_flt = |live[NSRC-1:SRC_ADC_FIRST];
            default:     adc_flt = 1'b0;
        endcase
        dac_src = live;
        if (dcfg_r.dac_startup_fault_pd_inhibit && dac_powering_up)
            dac_src[SRC_DRV_VG] = 1'b0;
        unique case (dcfg_r.dac_fault_powerdown_sel)
            PD_UNMASKED: dac_flt = |(dac_src[SRC_REG_SC:0] & ~mask_r[SRC_REG_SC:0]);
            PD_ALL:      dac_flt = |dac_src[SRC_REG_SC:0];
            default:     dac_flt = 1'b0;
        endcase
        adc_pd_nxt = adc_pd_r;
        if (adc_flt)
            adc_pd_nxt = 1'b1;
        else if (!icfg_r.adc_fault_recovery_sel || adc_repower)
            adc_pd_nxt = 1'b0;
        dac_pd_nxt = dac_pd_r;
        if (dac_flt)
            dac_pd_nxt = 1'b1;
        else if (!dcfg_r.dac_fault_recovery_sel || dac_repower)
            dac_pd_nxt = 1'b0;
    end

    // Interrupt pin shaping
    always_comb begin
        tmr_nxt      = tmr_r;
        pulse_on_nxt = pulse_on_r;
        assert_lvl   = 1'b0;
        unique case (icfg_r.mode)
            CIFC_MODE_STICKY: begin
                assert_lvl = |unm_sticky;
                tmr_nxt    = '0;
            end
            CIFC_MODE_LIVE: begin
                assert_lvl = |unm_live;
                tmr_nxt    = '0;
            end
            CIFC_MODE_REPEAT: begin
                if (|unm_sticky) begin
                    tmr_nxt = (32'(tmr_r) >= PERIOD_CYC - 1) ? '0 : tmr_r + 1'b1;
                    assert_lvl = 32'(tmr_r) < PULSE_CYC;
                end else begin
                    tmr_nxt = '0;
                end
            end
            CIFC_MODE_ONCE: begin
                // A new event during a pulse restarts it rather than queueing
                if (|(rise & ~mask_r)) begin
                    pulse_on_nxt = 1'b1;
                    tmr_nxt      = '0;
                end else if (pulse_on_r) begin
                    if (32'(tmr_r) >= PULSE_CYC - 1)
                        pulse_on_nxt = 1'b0;
                    else
                        tmr_nxt = tmr_r + 1'b1;
                end
                assert_lvl = pulse_on_r;
            end
        endcase
        if (icfg_r.mode != CIFC_MODE_ONCE)
            pulse_on_nxt = 1'b0;
        irq_nxt = icfg_r.irq_polarity_sel ? assert_lvl : ~assert_lvl;
    end

    // Block events: ADC and DAC power-down entry
    always_comb begin
        ev_sts_nxt = ev_sts_r;
        if (bus.wr && bus.addr == ADDR_EV_CLR)
            ev_sts_nxt = ev_sts_r & ~bus.wdata[1:0];
        // Set wins over a clear in the same cycle
        ev_sts_nxt = ev_sts_nxt | {dac_pd_nxt & ~dac_pd_r, adc_pd_nxt & ~adc_pd_r};
        ev_irq_nxt = |(ev_sts_nxt & ev_en_nxt);
    end

    always_comb begin
        rdata_nxt = 8'h00;
        if (bus.rd) begin
            unique case (bus.addr)
                ADDR_IRQ_CFG: rdata_nxt = icfg_r;
                ADDR_DAC_CFG: rdata_nxt = dcfg_r;
                ADDR_STICKY:  rdata_nxt = icfg_r.sticky_readback_sel ? unm_sticky
                                                                     : sticky_r;
                ADDR_LIVE:    rdata_nxt = live;
                ADDR_MASK:    rdata_nxt = mask_r;
                ADDR_CTRL:    rdata_nxt = {6'h00, dac_pd_r, adc_pd_r};
                ADDR_EV_STS:  rdata_nxt = {6'h00, ev_sts_r};
                ADDR_EV_EN:   rdata_nxt = {6'h00, ev_en_r};
                default:      rdata_nxt = 8'h00;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            icfg_r     <= cifc_irq_cfg_type'(IRQ_CFG_RST);
            dcfg_r     <= cifc_dac_cfg_type'(DAC_CFG_RST);
            mask_r     <= MASK_RST;
            sticky_r   <= '0;
            live_d_r   <= '0;
            adc_pd_r   <= 1'b0;
            dac_pd_r   <= 1'b0;
            tmr_r      <= '0;
            pulse_on_r <= 1'b0;
            irq_r      <= 1'b1;
            rdata_r    <= 8'h00;
            ev_sts_r   <= 2'h0;
            ev_en_r    <= 2'h0;
            ev_irq_r   <= 1'b0;
        end else begin
            icfg_r     <= icfg_nxt;
            dcfg_r     <= dcfg_nxt;
            mask_r     <= mask_nxt;
            sticky_r   <= sticky_nxt;
            live_d_r   <= live;
            adc_pd_r   <= adc_pd_nxt;
            dac_pd_r   <= dac_pd_nxt;
            tmr_r      <= tmr_nxt;
            pulse_on_r <= pulse_on_nxt;
            irq_r      <= irq_nxt;
            rdata_r    <= rdata_nxt;
            ev_sts_r   <= ev_sts_nxt;
            ev_en_r    <= ev_en_nxt;
            ev_irq_r   <= ev_irq_nxt;
        end
    end

    assign rdata   = rdata_r;
    assign irq_pin = irq_r;
    assign adc_pd  = adc_pd_r;
    assign dac_pd  = dac_pd_r;
    assign ev_irq  = ev_irq_r;
endmodule // cifc_top

// ===== testbench/cifc_fault_model.sv
// Fault source model: analog comparators seen as plain levels.
// Assumes the bench requests levels; they change only after a clock edge.
`timescale 1ns/10ps
module cifc_fault_model (
    input  wire logic       mclk,
    input  wire logic [7:0] want,
    output logic      [7:0] fault_pin
);
    // Unknown only before the first edge, while the block is still in reset
    always @(posedge mclk) fault_pin <= want;
endmodule // cifc_fault_model

// ===== testbench/cifc_top_asserts.sv
// Checker for the interrupt pin and fault power-down ports.
// Assumes it is bound into cifc_top; register writes are shadowed here.
`timescale 1ns/10ps
module cifc_top_asserts
    import cifc_pkg::*;
#(
    parameter int unsigned PULSE_CYC  = PULSE_CYC_DFLT,
    parameter int unsigned PERIOD_CYC = PERIOD_CYC_DFLT
) (
    input wire logic                      mclk,
    input wire logic                      rst_n,
    input wire cifc_pkg::cifc_bus_type    bus,
    input wire logic [7:0]                rdata,
    input wire logic [cifc_pkg::NSRC-1:0] fault_pin,
    input wire logic                      dac_powering_up,
    input wire logic                      adc_repower,
    input wire logic                      dac_repower,
    input wire logic                      irq_pin,
    input wire logic                      adc_pd,
    input wire logic                      dac_pd,
    input wire logic                      ev_irq
);
    logic [7:0]  cfg_r;
    logic [7:0]  mask_r;
    logic [7:0]  dac_r;
    logic [23:0] hi_r;
    logic [7:0]  um;
    assign um = fault_pin & ~mask_r;
    // Bit 3 of the DAC config is status, so the shadow keeps it clear
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_r  <= IRQ_CFG_RST;
            mask_r <= MASK_RST;
            dac_r  <= DAC_CFG_RST;
            hi_r   <= '0;
        end else begin
            if (bus.wr && bus.addr == ADDR_IRQ_CFG) cfg_r <= bus.wdata;
            if (bus.wr && bus.addr == ADDR_MASK) mask_r <= bus.wdata;
            if (bus.wr && bus.addr == ADDR_DAC_CFG) dac_r <= bus.wdata & 8'h77;
            hi_r <= (!bus.wr && cfg_r[6:5] == 2'h2 && irq_pin == cfg_r[7]) ? hi_r + 24'h1 : '0;
        end
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    sequence s_read_dac;
        $stable(dac_pd) ##1 (bus.rd && bus.addr == ADDR_DAC_CFG && $stable(dac_pd));
    endsequence
    a_dac_cfg_read: assert property (bus.rd && bus.addr == ADDR_DAC_CFG |=> (rdata & 8'hf7) == dac_r)
        else $error("dac config readback wrong");
    a_masked_idle: assert property ((mask_r == 8'hff && !cfg_r[6] && $stable(cfg_r)) [*3] |-> irq_pin == !cfg_r[7])
        else $error("irq pin not idle");
    // Pin to sticky to pin takes four edges, so the window is five samples
    a_sticky_level: assert property ((!cfg_r[6] && |(um & 8'hf8) && $stable(cfg_r) && $stable(mask_r)) [*5] |-> irq_pin == cfg_r[7])
        else $error("irq pin not asserted");
    a_live_quiet: assert property ((cfg_r[6:5] == 2'h1 && um == 8'h00 && $stable(cfg_r) && $stable(mask_r)) [*4] |-> irq_pin != cfg_r[7])
        else $error("irq pin not following live");
    a_repeat_width: assert property (cfg_r[6:5] == 2'h2 |-> hi_r <= PULSE_CYC)
        else $error("repeat pulse too long");
    a_adc_cause: assert property ($rose(adc_pd) |-> (^$past(cfg_r[4:3]) || ^$past(cfg_r[4:3], 2)) && |($past(fault_pin[7:3], 2) | $past(fault_pin[7:3], 3) | $past(fault_pin[7:3], 4)))
        else $error("adc power-down without cause");
    a_adc_auto: assert property ((!cfg_r[1] && fault_pin[7:3] == 5'h00) [*5] |-> !adc_pd)
        else $error("adc not recovered");
    a_dac_flag: assert property (s_read_dac |=> rdata[3] == $past(dac_pd))
        else $error("dac status bit wrong");
    a_dac_manual: assert property ($fell(dac_pd) |-> !($past(dac_r[4]) && $past(dac_r[4], 2)) || $past(dac_repower) || $past(dac_repower, 2))
        else $error("dac recovered without repower");
endmodule // cifc_top_asserts
bind cifc_top cifc_top_asserts #(
    .PULSE_CYC (PULSE_CYC),
    .PERIOD_CYC(PERIOD_CYC)
) u_chk (
    .mclk           (mclk),
    .rst_n          (rst_n),
    .bus            (bus),
    .rdata          (rdata),
    .fault_pin      (fault_pin),
    .dac_powering_up(dac_powering_up),
    .adc_repower    (adc_repower),
    .dac_repower    (dac_repower),
    .irq_pin        (irq_pin),
    .adc_pd         (adc_pd),
    .dac_pd         (dac_pd),
    .ev_irq         (ev_irq)
);

// ===== testbench/cifc_top_tb_top.sv
// Bench for the interrupt pin and fault power-down block.
// Assumes short pulse parameters and the fault model on the fault pins.
`timescale 1ns/10ps
module cifc_top_tb_top;
    import cifc_pkg::*;
    localparam int unsigned PC = 20;
    localparam int unsigned PR = 40;
    logic         mclk = 1'b0;
    logic         rst_n = 1'b0;
    cifc_bus_type bus = '0;
    logic [7:0]   want = 8'h00;
    logic [7:0]   fault_pin;
    logic [7:0]   rdata;
    logic         dac_powering_up = 1'b0;
    logic         adc_repower = 1'b0;
    logic         dac_repower = 1'b0;
    logic         irq_pin;
    logic         adc_pd;
    logic         dac_pd;
    logic         ev_irq;
    int           fail_count = 0;
    int           total_checks = 0;
    int           c;
    always #5 mclk = ~mclk;
    cifc_fault_model u_fm (.mclk(mclk), .want(want), .fault_pin(fault_pin));
    cifc_top #(.PULSE_CYC(PC), .PERIOD_CYC(PR)) dut (
        .mclk           (mclk),
        .rst_n          (rst_n),
        .bus            (bus),
        .rdata          (rdata),
        .fault_pin      (fault_pin),
        .dac_powering_up(dac_powering_up),
        .adc_repower    (adc_repower),
        .dac_repower    (dac_repower),
        .irq_pin        (irq_pin),
        .adc_pd         (adc_pd),
        .dac_pd         (dac_pd),
        .ev_irq         (ev_irq)
    );
    task automatic end_of_test();
        if (fail_count == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("Error at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge mclk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk) bus <= '{a, d, 1'b1, 1'b0};
        @(posedge mclk) bus.wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge mclk) bus <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge mclk) bus.rd <= 1'b0;
        #1 chk(rdata, e);
    endtask
    // A level that never comes ends the run rather than hanging
    task automatic wfor(input int s, input logic e);
        logic v;
        for (int i = 0; i < 12; i++) begin
            @(posedge mclk) #1 v = s == 0 ? adc_pd : s == 1 ? dac_pd : irq_pin;
            if (v === e) break;
        end
        chk({7'h00, v}, {7'h00, e});
        if (v !== e) end_of_test();
    endtask
    task automatic cnt_low(input int n);
        c = 0;
        repeat (n) begin
            @(posedge mclk) #1 if (irq_pin === 1'b0) c++;
        end
    endtask
    task automatic t_reset();
        rd(ADDR_IRQ_CFG, 8'h00);
        rd(ADDR_DAC_CFG, 8'h50);
        rd(8'h7f, 8'h00);
        chk({7'h00, irq_pin}, 8'h01);
        wr(ADDR_DAC_CFG, 8'hff);
        rd(ADDR_DAC_CFG, 8'h77);
        wr(ADDR_DAC_CFG, 8'h50);
    endtask
    task automatic t_sticky();
        wr(ADDR_MASK, 8'h00);
        @(posedge mclk) want <= 8'h08;
        wt(5);
        rd(ADDR_STICKY, 8'h08);
        rd(ADDR_STICKY, 8'h08);
        chk({7'h00, irq_pin}, 8'h00);
        wr(ADDR_MASK, 8'h08);
        wr(ADDR_IRQ_CFG, 8'h04);
        rd(ADDR_STICKY, 8'h00);
        wr(ADDR_IRQ_CFG, 8'h80);
        wr(ADDR_MASK, 8'h00);
        wt(2);
        #1 chk({7'h00, irq_pin}, 8'h01);
        @(posedge mclk) want <= 8'h00;
        wt(5);
        rd(ADDR_STICKY, 8'h08);
        rd(ADDR_STICKY, 8'h00);
        wfor(2, 1'b0);
    endtask
    task automatic t_modes();
        wr(ADDR_IRQ_CFG, 8'h20);
        @(posedge mclk) want <= 8'h10;
        wfor(2, 1'b0);
        @(posedge mclk) want <= 8'h00;
        wfor(2, 1'b1);
        rd(ADDR_STICKY, 8'h10);
        wr(ADDR_IRQ_CFG, 8'h60);
        @(posedge mclk) want <= 8'h20;
        cnt_low(3 * PC);
        chk(8'(c), 8'(PC));
        wr(ADDR_IRQ_CFG, 8'h40);
        cnt_low(5);
        cnt_low(2 * PR);
        chk(8'(c), 8'(2 * PC));
        @(posedge mclk) want <= 8'h00;
        wt(5);
        rd(ADDR_STICKY, 8'h20);
        wfor(2, 1'b1);
        wr(ADDR_IRQ_CFG, 8'h00);
    endtask
    task automatic t_adc();
        @(posedge mclk) want <= 8'h08;
        wt(6);
        #1 chk({7'h00, adc_pd}, 8'h00);
        wr(ADDR_IRQ_CFG, 8'h10);
        wfor(0, 1'b1);
        rd(ADDR_EV_STS, 8'h01);
        chk({7'h00, ev_irq}, 8'h00);
        wr(ADDR_EV_EN, 8'h01);
        wt(2);
        #1 chk({7'h00, ev_irq}, 8'h01);
        wr(ADDR_EV_CLR, 8'h01);
        wt(2);
        #1 chk({7'h00, ev_irq}, 8'h00);
        @(posedge mclk) want <= 8'h00;
        wfor(0, 1'b0);
        wr(ADDR_IRQ_CFG, 8'h12);
        @(posedge mclk) want <= 8'h08;
        wfor(0, 1'b1);
        @(posedge mclk) want <= 8'h00;
        wt(8);
        #1 chk({7'h00, adc_pd}, 8'h01);
        @(posedge mclk) adc_repower <= 1'b1;
        @(posedge mclk) adc_repower <= 1'b0;
        wfor(0, 1'b0);
    endtask
    task automatic t_dac();
        @(posedge mclk) want <= 8'h01;
        wfor(1, 1'b1);
        rd(ADDR_DAC_CFG, 8'h58);
        @(posedge mclk) want <= 8'h00;
        wt(8);
        #1 chk({7'h00, dac_pd}, 8'h01);
        @(posedge mclk) dac_repower <= 1'b1;
        @(posedge mclk) dac_repower <= 1'b0;
        wfor(1, 1'b0);
        wr(ADDR_DAC_CFG, 8'h54);
        @(posedge mclk) dac_powering_up <= 1'b1;
        @(posedge mclk) want <= 8'h01;
        wt(8);
        #1 chk({7'h00, dac_pd}, 8'h00);
        wr(ADDR_DAC_CFG, 8'h50);
        wfor(1, 1'b1);
        wr(ADDR_DAC_CFG, 8'h52);
        @(posedge mclk) want <= 8'h02;
        wt(6);
        rd(ADDR_LIVE, 8'h00);
        wr(ADDR_DAC_CFG, 8'h51);
        @(posedge mclk) want <= 8'h04;
        wt(6);
        rd(ADDR_LIVE, 8'h00);
        wr(ADDR_DAC_CFG, 8'h50);
        wt(4);
        rd(ADDR_LIVE, 8'h04);
    endtask
    // Selector value 1: masked faults must not power anything down
    task automatic t_unmasked();
        @(posedge mclk) want <= 8'h00;
        wr(ADDR_IRQ_CFG, 8'h08);
        wr(ADDR_DAC_CFG, 8'h20);
        wr(ADDR_MASK, 8'h11);
        @(posedge mclk) want <= 8'h11;
        wt(8);
        #1 chk({6'h00, dac_pd, adc_pd}, 8'h00);
        wr(ADDR_MASK, 8'h00);
        wfor(0, 1'b1);
        wfor(1, 1'b1);
        rd(ADDR_CTRL, 8'h03);
        @(posedge mclk) want <= 8'h00;
        wfor(0, 1'b0);
        wfor(1, 1'b0);
    endtask
    initial begin
        wt(5);
        rst_n <= 1'b1;
        t_reset();
        t_sticky();
        t_modes();
        t_adc();
        t_dac();
        t_unmasked();
        end_of_test();
    end
endmodule // cifc_top_tb_top
